// ==== lsc_table.sv ====
`timescale 1ns/100ps
`default_nettype none

package lsc_pkg;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned TABLE_BITS  = 16;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_TABLE0  = 8'h04;
  localparam logic [7:0] ADDR_TABLE1  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;

  // operating modes
  localparam logic [1:0] MODE_LOGIC  = 2'h0;
  localparam logic [1:0] MODE_RIPPLE = 2'h1;
  localparam logic [1:0] MODE_RAM    = 2'h2;
  localparam logic [1:0] MODE_ROM    = 2'h3;

  // ripple operations
  localparam logic [2:0] OP_ADD    = 3'h0;
  localparam logic [2:0] OP_SUB    = 3'h1;
  localparam logic [2:0] OP_ADDSUB = 3'h2;
  localparam logic [2:0] OP_UP     = 3'h3;
  localparam logic [2:0] OP_DOWN   = 3'h4;
  localparam logic [2:0] OP_MULT   = 3'h5;
  localparam logic [2:0] OP_CMP    = 3'h6;

  // control register fields
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_OP_LSB    = 2;
  localparam int unsigned CTRL_SRVAL_LSB = 5;
  localparam int unsigned CTRL_LOCK_BIT  = 7;

  // status register fields
  localparam int unsigned ST_COMB_LSB = 0;
  localparam int unsigned ST_REG_LSB  = 2;
  localparam int unsigned ST_COUT     = 4;
  localparam int unsigned ST_GEN      = 5;
  localparam int unsigned ST_PROP     = 6;
  localparam int unsigned ST_GE       = 7;
  localparam int unsigned ST_NE       = 8;
  localparam int unsigned ST_LE       = 9;
  localparam int unsigned ST_WIDE_LO  = 10;
  localparam int unsigned ST_WIDE_HI  = 11;
  localparam int unsigned ST_RAM_CAP  = 12;

  // reset values
  localparam logic [1:0]  RST_MODE  = MODE_LOGIC;
  localparam logic [2:0]  RST_OP    = OP_ADD;
  localparam logic [1:0]  RST_SRVAL = 2'h0;
  localparam logic [15:0] RST_TABLE = 16'h0000;

  typedef struct packed {
    logic [1:0]  mode;
    logic [2:0]  op;
    logic [1:0]  srval;
    logic        lock;
    logic [15:0] tab0;
    logic [15:0] tab1;
    logic [1:0]  q;
    logic        ack;
    logic [31:0] dat;
  } lsc_state_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module lsc_table #(
  parameter int unsigned BITS = lsc_pkg::TABLE_BITS
) (
  input  wire logic [BITS-1:0]         table_i,
  input  wire logic [$clog2(BITS)-1:0] index_i,
  output logic                         out_o
);
  // one stored bit per input combination: any function of four inputs
  assign out_o = table_i[index_i];
endmodule // lsc_table

`default_nettype wire

// ==== lsc_slice.sv ====
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module lsc_slice #(
  parameter bit RAM_CAPABLE = 1'b1
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [lsc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [1:0]                 a_i,
  input  wire logic [1:0]                 b_i,
  input  wire logic [1:0]                 c_i,
  input  wire logic [1:0]                 d_i,
  input  wire logic [1:0]                 m_i,
  input  wire logic                       ce_i,
  input  wire logic                       local_set_reset_i,
  input  wire logic                       carry_chain_in_i,
  input  wire logic [1:0]                 wide_in_i,
  input  wire logic                       ram_we_i,
  input  wire logic [1:0]                 ram_wd_i,
  output logic      [1:0]                 comb_out_o,
  output logic      [1:0]                 reg_out_o,
  output logic                            wide_mux_out_lo_o,
  output logic                            wide_mux_out_hi_o,
  output logic                            carry_chain_out_o,
  output logic                            carry_gen_o,
  output logic                            carry_prop_o,
  output logic                            cmp_ge_o,
  output logic                            cmp_ne_o,
  output logic                            cmp_le_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  lsc_pkg::lsc_state_t st;
  lsc_pkg::lsc_state_t next_st;

  logic [3:0]  tidx [2];
  logic [1:0]  tout;
  logic [1:0]  opa;
  logic [1:0]  opb;
  logic [2:0]  sum_nc;
  logic [2:0]  sum_c;
  logic [1:0]  fcomb;
  logic        gen;
  logic        prop;
  logic        cout;
  logic        is_ripple;
  logic        is_cmp;
  logic        bus_req;
  logic        bus_wr;
  logic        tab_wr_ok;
  logic [31:0] status;
  logic [31:0] rd_data;
  logic [1:0]  ram_wdata;

  // table address: ram mode shares port 0 address across both tables,
  // since the memory is single-port
  // pins is {d, c, b, a}; passed as an argument so that a continuous
  // assignment calling this wakes on every pin change
  function automatic logic [3:0] table_index(input logic [1:0] mode,
                                             input logic [7:0] pins,
                                             input int unsigned k);
    logic [3:0] idx;
    idx = {pins[6+k], pins[4+k], pins[2+k], pins[k]};
    if (mode == lsc_pkg::MODE_RAM) begin
      idx = {pins[6], pins[4], pins[2], pins[0]};
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // the two lookup tables

  for (genvar k = 0; k < 2; k++) begin : g_tab
    assign tidx[k] = table_index(st.mode, {d_i, c_i, b_i, a_i}, k);
    lsc_table #(
      .BITS (lsc_pkg::TABLE_BITS)
    ) u_table (
      .table_i (k == 0 ? st.tab0 : st.tab1),
      .index_i (tidx[k]),
      .out_o   (tout[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // ripple arithmetic

  assign opa       = a_i;
  assign is_ripple = (st.mode == lsc_pkg::MODE_RIPPLE);
  assign is_cmp    = is_ripple && (st.op == lsc_pkg::OP_CMP);

  // counters and subtraction rely on the lowest slice of a chain tying
  // carry_chain_in: high for up count and subtract, low for down count
  always_comb begin
    unique case (st.op)
      lsc_pkg::OP_SUB:    opb = ~b_i;
      lsc_pkg::OP_ADDSUB: opb = m_i[0] ? b_i : ~b_i;
      lsc_pkg::OP_UP:     opb = 2'h0;
      lsc_pkg::OP_DOWN:   opb = 2'h3;
      lsc_pkg::OP_MULT:   opb = b_i & {2{m_i[0]}};
      lsc_pkg::OP_CMP:    opb = ~b_i;
      default:            opb = b_i;
    endcase
  end

  assign sum_nc = {1'b0, opa} + {1'b0, opb};
  assign sum_c  = sum_nc + {2'h0, carry_chain_in_i};
  // generate and propagate let a neighbour look ahead across this slice
  assign gen    = sum_nc[2];
  assign prop   = &(opa ^ opb);
  assign cout   = gen | (prop & carry_chain_in_i);

  ////////////////////////////////////////////////////////////////////////////
  // mode selection of the combinational outputs

  always_comb begin
    unique case (st.mode)
      lsc_pkg::MODE_RIPPLE: fcomb = sum_c[1:0];
      default:              fcomb = tout;
    endcase
  end

  assign comb_out_o        = fcomb;
  assign wide_mux_out_lo_o = m_i[0] ? tout[1] : tout[0];
  assign wide_mux_out_hi_o = m_i[1] ? wide_in_i[1] : wide_in_i[0];
  assign carry_chain_out_o = is_ripple & cout;
  assign carry_gen_o       = is_ripple & gen;
  assign carry_prop_o      = is_ripple & prop;
  assign cmp_ge_o          = is_cmp & (a_i >= b_i);
  assign cmp_ne_o          = is_cmp & (a_i != b_i);
  assign cmp_le_o          = is_cmp & (a_i <= b_i);
  assign reg_out_o         = st.q;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  assign bus_req  = wb_cyc_i & wb_stb_i;
  // the write lands at the edge where the master sees ack
  assign bus_wr   = bus_req & wb_we_i & st.ack;
  // once locked the tables are frozen rom contents; ram mode still
  // writes them from the fabric
  assign tab_wr_ok = ~st.lock;
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;

  always_comb begin
    status = 32'h0000_0000;
    status[lsc_pkg::ST_COMB_LSB +: 2] = fcomb;
    status[lsc_pkg::ST_REG_LSB +: 2]  = st.q;
    status[lsc_pkg::ST_COUT]          = carry_chain_out_o;
    status[lsc_pkg::ST_GEN]           = carry_gen_o;
    status[lsc_pkg::ST_PROP]          = carry_prop_o;
    status[lsc_pkg::ST_GE]            = cmp_ge_o;
    status[lsc_pkg::ST_NE]            = cmp_ne_o;
    status[lsc_pkg::ST_LE]            = cmp_le_o;
    status[lsc_pkg::ST_WIDE_LO]       = wide_mux_out_lo_o;
    status[lsc_pkg::ST_WIDE_HI]       = wide_mux_out_hi_o;
    status[lsc_pkg::ST_RAM_CAP]       = RAM_CAPABLE;
  end

  always_comb begin
    unique case (wb_adr_i)
      lsc_pkg::ADDR_CTRL:   rd_data = {24'h00_0000, st.lock, st.srval,
                                       st.op, st.mode};
      lsc_pkg::ADDR_TABLE0: rd_data = {16'h0000, st.tab0};
      lsc_pkg::ADDR_TABLE1: rd_data = {16'h0000, st.tab1};
      lsc_pkg::ADDR_STATUS: rd_data = status;
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  assign ram_wdata = ram_wd_i;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st     = st;
    next_st.ack = bus_req & ~st.ack;
    if (bus_req & ~st.ack) begin
      next_st.dat = rd_data;
    end

    // fabric writes into the tables in ram mode
    if (st.mode == lsc_pkg::MODE_RAM && RAM_CAPABLE && ram_we_i) begin
      next_st.tab0[tidx[0]] = ram_wdata[0];
      next_st.tab1[tidx[1]] = ram_wdata[1];
    end

    // bus writes; a bus write to a table wins over a same-cycle ram write
    if (bus_wr) begin
      unique case (wb_adr_i)
        lsc_pkg::ADDR_CTRL: begin
          if (wb_sel_i[0]) begin
            if (RAM_CAPABLE ||
                wb_dat_i[lsc_pkg::CTRL_MODE_LSB +: 2] != lsc_pkg::MODE_RAM)
            begin
              next_st.mode = wb_dat_i[lsc_pkg::CTRL_MODE_LSB +: 2];
            end
            next_st.op    = wb_dat_i[lsc_pkg::CTRL_OP_LSB +: 3];
            next_st.srval = wb_dat_i[lsc_pkg::CTRL_SRVAL_LSB +: 2];
            // lock is sticky until reset
            next_st.lock  = st.lock | wb_dat_i[lsc_pkg::CTRL_LOCK_BIT];
          end
        end
        lsc_pkg::ADDR_TABLE0: begin
          if (tab_wr_ok && wb_sel_i[0]) next_st.tab0[7:0]  = wb_dat_i[7:0];
          if (tab_wr_ok && wb_sel_i[1]) next_st.tab0[15:8] = wb_dat_i[15:8];
        end
        lsc_pkg::ADDR_TABLE1: begin
          if (tab_wr_ok && wb_sel_i[0]) next_st.tab1[7:0]  = wb_dat_i[7:0];
          if (tab_wr_ok && wb_sel_i[1]) next_st.tab1[15:8] = wb_dat_i[15:8];
        end
        default: begin
        end
      endcase
    end

    // slice flops: set/reset dominates, then clock enable
    if (local_set_reset_i) begin
      next_st.q = st.srval;
    end else if (ce_i) begin
      next_st.q = fcomb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= '0;
      st.mode  <= lsc_pkg::RST_MODE;
      st.op    <= lsc_pkg::RST_OP;
      st.srval <= lsc_pkg::RST_SRVAL;
      st.tab0  <= lsc_pkg::RST_TABLE;
      st.tab1  <= lsc_pkg::RST_TABLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_mode_write;
    bus_wr && wb_adr_i == lsc_pkg::ADDR_CTRL && wb_sel_i[0] &&
      wb_dat_i[1:0] != lsc_pkg::MODE_RAM |=> st.mode == $past(wb_dat_i[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write not taken");

  property p_no_ram;
    !RAM_CAPABLE |-> st.mode != lsc_pkg::MODE_RAM;
  endproperty
  a_no_ram: assert property (p_no_ram)
    else $error("ram mode in logic-only slice");

  property p_logic_out;
    st.mode == lsc_pkg::MODE_LOGIC |->
      comb_out_o == {st.tab1[{d_i[1], c_i[1], b_i[1], a_i[1]}],
                     st.tab0[{d_i[0], c_i[0], b_i[0], a_i[0]}]};
  endproperty
  a_logic_out: assert property (p_logic_out)
    else $error("logic mode output wrong");

  property p_wide_lo;
    st.mode == lsc_pkg::MODE_LOGIC |->
      wide_mux_out_lo_o == (m_i[0] ? comb_out_o[1] : comb_out_o[0]);
  endproperty
  a_wide_lo: assert property (p_wide_lo)
    else $error("five-input mux wrong");

  property p_wide_hi;
    wide_mux_out_hi_o == wide_in_i[m_i[1]];
  endproperty
  a_wide_hi: assert property (p_wide_hi)
    else $error("wide cascade mux wrong");

  property p_add;
    is_ripple && st.op == lsc_pkg::OP_ADD |->
      {carry_chain_out_o, comb_out_o} ==
        3'({1'b0, a_i} + {1'b0, b_i} + {2'h0, carry_chain_in_i});
  endproperty
  a_add: assert property (p_add)
    else $error("ripple add wrong");

  property p_cmp;
    is_cmp |-> cmp_ge_o == (a_i >= b_i) && cmp_le_o == (a_i <= b_i) &&
               cmp_ne_o == (a_i != b_i);
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare flags wrong");

  property p_carry;
    is_ripple |->
      carry_chain_out_o == (carry_gen_o | (carry_prop_o & carry_chain_in_i));
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry lookahead terms inconsistent");

  property p_ram_write;
    st.mode == lsc_pkg::MODE_RAM && ram_we_i && !bus_wr && !rst_i |=>
      $stable(tidx[0]) |-> comb_out_o == $past(ram_wd_i);
  endproperty
  a_ram_write: assert property (p_ram_write)
    else $error("ram write not read back");

  property p_rom_fixed;
    st.lock && st.mode != lsc_pkg::MODE_RAM |=>
      $stable(st.tab0) && $stable(st.tab1);
  endproperty
  a_rom_fixed: assert property (p_rom_fixed)
    else $error("locked table changed");

  property p_capture;
    !local_set_reset_i && ce_i |=> reg_out_o == $past(comb_out_o);
  endproperty
  a_capture: assert property (p_capture)
    else $error("flop did not capture comb_out");

  property p_setreset;
    local_set_reset_i |=> reg_out_o == $past(st.srval);
  endproperty
  a_setreset: assert property (p_setreset)
    else $error("set/reset value not taken");

  property p_hold;
    !local_set_reset_i && !ce_i |=> $stable(reg_out_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flop changed without enable");

  property p_ack;
    bus_req && !st.ack |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not single cycle");

  c_ripple_carry: cover property (is_ripple && carry_chain_out_o);
  c_ram_write: cover property (st.mode == lsc_pkg::MODE_RAM && ram_we_i);
  c_locked_rom: cover property (st.lock && st.mode == lsc_pkg::MODE_ROM);
  c_cmp_eq: cover property (is_cmp && !cmp_ne_o);

endmodule // lsc_slice

`default_nettype wire

// ==== lsc_fabric.sv ====
`timescale 1ns/100ps
`default_nettype none

// routing fabric and neighbour cells: one retiming stage between cells,
// so every fabric input changes just after a rising edge
module lsc_fabric (
  input  wire logic        clk_i,
  input  wire logic [17:0] route_i,
  output logic      [1:0]  a_o,
  output logic      [1:0]  b_o,
  output logic      [1:0]  c_o,
  output logic      [1:0]  d_o,
  output logic      [1:0]  m_o,
  output logic             ce_o,
  output logic             lsr_o,
  output logic             carry_o,
  output logic      [1:0]  wide_o,
  output logic             ram_we_o,
  output logic      [1:0]  ram_wd_o
);
  logic [17:0] hold = 18'h0;

  always_ff @(posedge clk_i) begin
    hold <= route_i;
  end

  assign a_o      = hold[1:0];
  assign b_o      = hold[3:2];
  assign c_o      = hold[5:4];
  assign d_o      = hold[7:6];
  assign m_o      = hold[9:8];
  assign ce_o     = hold[10];
  assign lsr_o    = hold[11];
  assign carry_o  = hold[12];
  assign wide_o   = hold[14:13];
  assign ram_we_o = hold[15];
  assign ram_wd_o = hold[17:16];
endmodule // lsc_fabric

`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [3:0]  wsel     = 4'hf;
  logic        pick_lo  = 1'b0;
  logic [31:0] dat_lo;
  logic        ack_lo;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  wire  logic [1:0] a_i, b_i, c_i, d_i, m_i, wide_in_i, ram_wd_i;
  wire  logic       ce_i, local_set_reset_i, carry_chain_in_i, ram_we_i;
  logic [1:0]  comb_out_o, reg_out_o;
  logic        wide_mux_out_lo_o, wide_mux_out_hi_o, carry_chain_out_o;
  logic        carry_gen_o, carry_prop_o, cmp_ge_o, cmp_ne_o, cmp_le_o;
  logic [17:0] fab      = 18'h0;
  logic        chk_en   = 1'b0;
  logic [1:0]  mode     = 2'h0;
  logic [2:0]  op       = 3'h0;
  logic [1:0]  srval    = 2'h0;
  logic [1:0]  exp_q    = 2'h0;
  logic [15:0] t0       = 16'h0;
  logic [15:0] t1       = 16'h0;
  logic [9:0]  ev;
  int unsigned miscompares = 0;
  int unsigned n_tests     = 0;
  wire  logic [9:0] seen = {cmp_le_o, cmp_ne_o, cmp_ge_o, carry_prop_o,
    carry_gen_o, carry_chain_out_o, wide_mux_out_hi_o, wide_mux_out_lo_o,
    comb_out_o};
  wire  logic [3:0] ram_adr = {d_i[0], c_i[0], b_i[0], a_i[0]};

  always #20 clk_i = ~clk_i;

  lsc_slice #(.RAM_CAPABLE(1'b1)) i_lsc_slice (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i & ~pick_lo),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .a_i(a_i), .b_i(b_i), .c_i(c_i), .d_i(d_i), .m_i(m_i), .ce_i(ce_i),
    .local_set_reset_i(local_set_reset_i),
    .carry_chain_in_i(carry_chain_in_i), .wide_in_i(wide_in_i),
    .ram_we_i(ram_we_i), .ram_wd_i(ram_wd_i), .comb_out_o(comb_out_o),
    .reg_out_o(reg_out_o), .wide_mux_out_lo_o(wide_mux_out_lo_o),
    .wide_mux_out_hi_o(wide_mux_out_hi_o),
    .carry_chain_out_o(carry_chain_out_o), .carry_gen_o(carry_gen_o),
    .carry_prop_o(carry_prop_o), .cmp_ge_o(cmp_ge_o), .cmp_ne_o(cmp_ne_o),
    .cmp_le_o(cmp_le_o)
  );

  lsc_fabric i_lsc_fabric (
    .clk_i(clk_i), .route_i(fab), .a_o(a_i), .b_o(b_i), .c_o(c_i),
    .d_o(d_i), .m_o(m_i), .ce_o(ce_i), .lsr_o(local_set_reset_i),
    .carry_o(carry_chain_in_i), .wide_o(wide_in_i), .ram_we_o(ram_we_i),
    .ram_wd_o(ram_wd_i)
  );

  // logic-only cell on the same fabric; the bus reaches it while picked
  lsc_slice #(.RAM_CAPABLE(1'b0)) i_lsc_slice_lo (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i & pick_lo),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(dat_lo),
    .wb_ack_o(ack_lo), .a_i(a_i), .b_i(b_i), .c_i(c_i), .d_i(d_i),
    .m_i(m_i), .ce_i(ce_i), .local_set_reset_i(local_set_reset_i),
    .carry_chain_in_i(carry_chain_in_i), .wide_in_i(wide_in_i),
    .ram_we_i(ram_we_i), .ram_wd_i(ram_wd_i), .comb_out_o(),
    .reg_out_o(), .wide_mux_out_lo_o(), .wide_mux_out_hi_o(),
    .carry_chain_out_o(), .carry_gen_o(), .carry_prop_o(), .cmp_ge_o(),
    .cmp_ne_o(), .cmp_le_o()
  );

  //////////////////////////////////////////////////////////////////////////////

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, want);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // expected fabric outputs: {le,ne,ge,prop,gen,cout,hi,lo,comb}
  function automatic logic [9:0] exp_out();
    logic [1:0] o, opb;
    logic [2:0] s, sg;
    logic [3:0] i0, i1;
    logic       lo, hi, p, ge, ne, le;
    i0 = {d_i[0], c_i[0], b_i[0], a_i[0]};
    // single port: both tables share the lower address in ram mode
    i1 = (mode == lsc_pkg::MODE_RAM) ? i0 : {d_i[1], c_i[1], b_i[1], a_i[1]};
    o = {t1[i1], t0[i0]};
    lo = m_i[0] ? o[1] : o[0];
    hi = m_i[1] ? wide_in_i[1] : wide_in_i[0];
    {s, sg, p, ge, ne, le} = 10'h0;
    if (mode == lsc_pkg::MODE_RIPPLE) begin
      case (op)
        lsc_pkg::OP_SUB, lsc_pkg::OP_CMP: opb = ~b_i;
        lsc_pkg::OP_ADDSUB: opb = m_i[0] ? b_i : ~b_i;
        lsc_pkg::OP_UP: opb = 2'h0;
        lsc_pkg::OP_DOWN: opb = 2'h3;
        lsc_pkg::OP_MULT: opb = b_i & {2{m_i[0]}};
        default: opb = b_i;
      endcase
      sg = {1'b0, a_i} + {1'b0, opb};
      s = sg + {2'h0, carry_chain_in_i};
      p = &(a_i ^ opb);
      o = s[1:0];
      if (op == lsc_pkg::OP_CMP) begin
        ge = a_i >= b_i;
        ne = a_i != b_i;
        le = a_i <= b_i;
      end
    end
    return {le, ne, ge, p, sg[2], s[2], hi, lo, o};
  endfunction

  // flop and ram model, fed with the values sampled at the edge
  always @(posedge clk_i) begin
    ev = exp_out();
    if (rst_i)
      exp_q = 2'h0;
    else if (local_set_reset_i)
      exp_q = srval;
    else if (ce_i)
      exp_q = ev[1:0];
    if (!rst_i && mode == lsc_pkg::MODE_RAM && ram_we_i) begin
      t0[ram_adr] = ram_wd_i[0];
      t1[ram_adr] = ram_wd_i[1];
    end
  end

  // every fabric-side output is compared in every mode
  always @(negedge clk_i) begin
    if (chk_en) begin
      check({22'h0, seen}, {22'h0, exp_out()});
      check({30'h0, reg_out_o}, {30'h0, exp_q});
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= wsel;
    // no cycle count is assumed: only the watchdog ends a hung wait
    do begin
      @(posedge clk_i);
    end while ((pick_lo ? ack_lo : wb_ack_o) !== 1'b1);
    r = pick_lo ? dat_lo : wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(r, e);
  endtask

  task automatic rw(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    logic [31:0] r;
    wb(1'b1, a, d, r);
    rd(a, e);
  endtask

  task automatic cfg(input logic [1:0] md, input logic [2:0] o,
                     input logic lk);
    logic [1:0] sv;
    sv = 2'($urandom);
    rw(lsc_pkg::ADDR_CTRL, {24'h0, lk, sv, o, md},
       {24'h0, lk, sv, o, md});
    mode = md;
    op = o;
    srval = sv;
  endtask

  // upper halves are random: they must read back as zero
  task automatic tables();
    logic [31:0] r0, r1;
    r0 = $urandom;
    r1 = $urandom;
    rw(lsc_pkg::ADDR_TABLE0, r0, {16'h0, r0[15:0]});
    rw(lsc_pkg::ADDR_TABLE1, r1, {16'h0, r1[15:0]});
    // byte enables: only the low byte of table 1 may change
    wsel <= 4'h1;
    rw(lsc_pkg::ADDR_TABLE1, ~r1, {16'h0, r1[15:8], ~r1[7:0]});
    wsel <= 4'hf;
    t0 = r0[15:0];
    t1 = {r1[15:8], ~r1[7:0]};
  endtask

  // fabric is quiet during bus cycles so mode changes never race the model
  task automatic run(input int n);
    chk_en <= 1'b1;
    repeat (n) begin
      @(posedge clk_i);
      fab <= 18'($urandom);
    end
    @(posedge clk_i);
    fab <= 18'h0;
    repeat (2) @(posedge clk_i);
    chk_en <= 1'b0;
  endtask

  task automatic stat();
    ev = exp_out();
    rd(lsc_pkg::ADDR_STATUS,
       {19'h0, 1'b1, ev[3], ev[2], ev[9:4], exp_q, ev[1:0]});
  endtask

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    mode = lsc_pkg::MODE_LOGIC;
    op = lsc_pkg::OP_ADD;
    srval = 2'h0;
    t0 = 16'h0;
    t1 = 16'h0;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h5bbfece5));
    reset_dut();
    // logic-only cell: a ram mode write is dropped, the other fields land
    pick_lo <= 1'b1;
    rw(lsc_pkg::ADDR_CTRL, 32'h0000_007e, 32'h0000_007c);
    rd(lsc_pkg::ADDR_STATUS, 32'h0);
    pick_lo <= 1'b0;
    rd(lsc_pkg::ADDR_CTRL, 32'h0);
    rd(lsc_pkg::ADDR_TABLE0, 32'h0);
    rw(8'h10, 32'hffffffff, 32'h0);
    rd(lsc_pkg::ADDR_CTRL, 32'h0);
    tables();
    cfg(lsc_pkg::MODE_LOGIC, lsc_pkg::OP_ADD, 1'b0);
    run(150);
    stat();
    tables();
    cfg(lsc_pkg::MODE_ROM, lsc_pkg::OP_ADD, 1'b0);
    run(150);
    stat();
    for (int k = 0; k < 8; k++) begin
      cfg(lsc_pkg::MODE_RIPPLE, 3'(k), 1'b0);
      run(40);
    end
    cfg(lsc_pkg::MODE_RAM, lsc_pkg::OP_ADD, 1'b0);
    run(200);
    cfg(lsc_pkg::MODE_ROM, lsc_pkg::OP_SUB, 1'b1);
    rw(lsc_pkg::ADDR_TABLE0, {16'h0, ~t0}, {16'h0, t0});
    run(60);
    reset_dut();
    rd(lsc_pkg::ADDR_TABLE0, 32'h0);
    rd(lsc_pkg::ADDR_CTRL, 32'h0);
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
